/* hdl/tcm_consts.svh */
// Functional notes
// [R1] - Ch4 direction 00 out, 01 own, 10 cross
// [R2] - Ch3 direction 00 out, 01 own, 10 cross
// [R3] - Code 11 routes trigger; needs internal source
// [R4] - Change direction only while channel disabled
// [R5] - Input mode: ch4 filter, dividers placed
// [R6] - Output mode: switch, control, buffer, immediate
// [R7] - Divider 1/2/4/8 edges, cleared when disabled
// [R8] - Filter needs N equal samples; 0000 none
// [R9] - Ch3 filter bits 7:4; reset zero, RW
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH

// Register byte addresses
`define TCM_ADDR_MODE     8'h00
`define TCM_ADDR_CTRL     8'h04
`define TCM_ADDR_STAT     8'h08

// Mode register fields, output view
`define TCM_F_CH4_SWITCH  15
`define TCM_F_CH4_CTRL    14:12
`define TCM_F_CH4_BUF     11
`define TCM_F_CH4_IMM     10
`define TCM_F_CH4_DIR     9:8
`define TCM_F_CH3_SWITCH  7
`define TCM_F_CH3_CTRL    6:4
`define TCM_F_CH3_BUF     3
`define TCM_F_CH3_IMM     2
`define TCM_F_CH3_DIR     1:0

// Mode register fields, input view
`define TCM_F_CH4_FILT    15:12
`define TCM_F_CH4_DIV     11:10
`define TCM_F_CH3_FILT    7:4
`define TCM_F_CH3_DIV     3:2

// Control register fields
`define TCM_F_CH3_EN      0
`define TCM_F_CH4_EN      1
`define TCM_F_TRIG_SEL    6:4

// Reset values
`define TCM_MODE_RST      16'h0000
`define TCM_CTRL_RST      7'h00

// Trigger selections up to this code are internal triggers
`define TCM_TRIG_INT_MAX  3'h3

// Filter tables, one nibble per code, code 0 in the low nibble
`define TCM_FILT_N_TAB    64'h8658658686868421
`define TCM_FILT_P_TAB    64'h5554443322110000

`endif

/* hdl/tcm_in_filter.sv */
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tcm_in_filter (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Pin and filter code
    input  wire logic       pin_in,
    input  wire logic [3:0] filter_code,
    // Filtered level
    output logic            filt_out
);
    import tcm_pkg::*;

    logic [2:0] sync_r;     // Three-stage pin synchroniser
    logic [2:0] sync_nxt;
    logic       stable_r;   // Level once stages two and three agree
    logic       stable_nxt;
    logic [4:0] pre_r;      // Sampling prescaler
    logic [4:0] pre_nxt;
    logic [3:0] cnt_r;      // Consecutive differing samples
    logic [3:0] cnt_nxt;
    logic       filt_r;     // Validated level
    logic       filt_nxt;
    logic [3:0] n_need;     // Samples needed for this code
    logic [2:0] p_exp;      // Log2 of sampling divisor
    logic [4:0] p_mask;
    logic       tick;

    assign filt_out = filt_r;

    // Next values: sync, prescaler, filter count
    always_comb begin
        n_need     = 4'(`TCM_FILT_N_TAB >> {filter_code, 2'b00});
        p_exp      = 3'(`TCM_FILT_P_TAB >> {filter_code, 2'b00});
        p_mask     = 5'((6'h01 << p_exp) - 6'h01);
        tick       = (pre_r & p_mask) == p_mask;
        sync_nxt   = {sync_r[1:0], pin_in};
        // Only stages two and three are compared, never stage one
        stable_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : stable_r;
        pre_nxt    = tick ? 5'h00 : 5'(pre_r + 5'h01);
        cnt_nxt    = cnt_r;
        filt_nxt   = filt_r;
        if (tick) begin
            // Any equal sample restarts the run
            if (stable_r == filt_r) begin
                cnt_nxt = 4'h0;
            end else if (4'(cnt_r + 4'h1) >= n_need) begin // [R8]
                filt_nxt = stable_r;
                cnt_nxt  = 4'h0;
            end else begin
                cnt_nxt = 4'(cnt_r + 4'h1);
            end
        end
    end

    // Register stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_r   <= 3'h0;
            stable_r <= 1'b0;
            pre_r    <= 5'h00;
            cnt_r    <= 4'h0;
            filt_r   <= 1'b0;
        end else begin
            sync_r   <= sync_nxt;
            stable_r <= stable_nxt;
            pre_r    <= pre_nxt;
            cnt_r    <= cnt_nxt;
            filt_r   <= filt_nxt;
        end
    end

    chk_filter_cause: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        $changed(filt_r) |-> $past(stable_r) == filt_r)
        else $error("filtered level moved without a differing sample");

    chk_nofilt_pass: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        (filter_code == 4'h0 && stable_r != filt_r) |=> filt_r == $past(stable_r))
        else $error("unfiltered input not passed in one cycle");

endmodule : tcm_in_filter

/* hdl/tcm_pkg.sv */
package tcm_pkg;

    // Channel direction and input source
    typedef enum logic [1:0] {
        TCM_DIR_OUT,
        TCM_DIR_OWN,
        TCM_DIR_CROSS,
        TCM_DIR_TRIG
    } tcm_dir_t;

    // Output-compare settings handed to the compare datapath
    typedef struct packed {
        logic       switch_en;
        logic [2:0] control;
        logic       buffer_en;
        logic       immediate_en;
    } tcm_out_cfg_t;

    // Capture view of one channel
    typedef struct packed {
        logic       is_input;
        logic       capture;
    } tcm_cap_t;

endpackage : tcm_pkg

/* hdl/tcm_top.sv */
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tcm_top #(
    parameter int AW = 8    // Decoded address width
) (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Channel pins and internal trigger
    input  wire logic                  ch3_pin,
    input  wire logic                  ch4_pin,
    input  wire logic                  slave_trigger_input,
    // Output-compare settings
    output tcm_pkg::tcm_out_cfg_t      ch3_out_cfg,
    output tcm_pkg::tcm_out_cfg_t      ch4_out_cfg,
    // Capture events
    output tcm_pkg::tcm_cap_t          ch3_cap,
    output tcm_pkg::tcm_cap_t          ch4_cap
);
    import tcm_pkg::*;

    // Bus state
    logic              wr_pend_r;     // Write data phase pending
    logic              wr_pend_nxt;
    logic [AW-1:0]     wr_addr_r;     // Address of pending write
    logic [AW-1:0]     wr_addr_nxt;
    logic [31:0]       rdata_r;
    logic [31:0]       rdata_nxt;
    logic              ready_r;
    logic              addr_phase;

    // Software registers
    logic [15:0]       mode_r;        // channel_three_four_mode
    logic [15:0]       mode_nxt;
    logic [6:0]        ctrl_r;        // Enables and trigger select
    logic [6:0]        ctrl_nxt;

    // Capture state
    logic [2:0]        div3_r;        // Edge counts toward a capture
    logic [2:0]        div3_nxt;
    logic [2:0]        div4_r;
    logic [2:0]        div4_nxt;
    logic              src3_q_r;      // Previous routed level
    logic              src4_q_r;
    logic [7:0]        cnt3_r;        // Captures seen, readable
    logic [7:0]        cnt3_nxt;
    logic [7:0]        cnt4_r;
    logic [7:0]        cnt4_nxt;
    tcm_cap_t          cap3_r;
    tcm_cap_t          cap3_nxt;
    tcm_cap_t          cap4_r;
    tcm_cap_t          cap4_nxt;
    tcm_out_cfg_t      oc3_r;
    tcm_out_cfg_t      oc4_r;

    // Routing
    logic              filt3;
    logic              filt4;
    logic              trig_ok;
    logic              src3;
    logic              src4;
    tcm_dir_t          dir3;
    tcm_dir_t          dir4;

    assign hrdata      = rdata_r;
    assign hreadyout   = ready_r;
    assign hresp       = 1'b0;
    assign ch3_out_cfg = oc3_r;
    assign ch4_out_cfg = oc4_r;
    assign ch3_cap     = cap3_r;
    assign ch4_cap     = cap4_r;

    // Filters sit on the pins; code fields from the input view
    tcm_in_filter u_filt3 (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .pin_in      (ch3_pin),
        .filter_code (mode_r[`TCM_F_CH3_FILT]), // [R9]
        .filt_out    (filt3)
    );

    tcm_in_filter u_filt4 (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .pin_in      (ch4_pin),
        .filter_code (mode_r[`TCM_F_CH4_FILT]), // [R5]
        .filt_out    (filt4)
    );

    // Source selection per channel
    always_comb begin
        dir3    = tcm_dir_t'(mode_r[`TCM_F_CH3_DIR]);
        dir4    = tcm_dir_t'(mode_r[`TCM_F_CH4_DIR]);
        // Trigger path is dead unless an internal source is picked
        trig_ok = ctrl_r[`TCM_F_TRIG_SEL] <= `TCM_TRIG_INT_MAX; // [R3]
        case (dir3)
            TCM_DIR_OWN:   src3 = filt3;                        // [R2]
            TCM_DIR_CROSS: src3 = filt4;                        // [R2]
            TCM_DIR_TRIG:  src3 = slave_trigger_input & trig_ok; // [R3]
            default:       src3 = 1'b0;
        endcase
        case (dir4)
            TCM_DIR_OWN:   src4 = filt4;                        // [R1]
            TCM_DIR_CROSS: src4 = filt3;                        // [R1]
            TCM_DIR_TRIG:  src4 = slave_trigger_input & trig_ok; // [R3]
            default:       src4 = 1'b0;
        endcase
    end

    // Bus and register next values; reads see a same-cycle write
    always_comb begin
        addr_phase  = hsel & hready & htrans[1];
        wr_pend_nxt = addr_phase & hwrite;
        wr_addr_nxt = addr_phase ? haddr[AW-1:0] : wr_addr_r;
        mode_nxt    = mode_r;
        ctrl_nxt    = ctrl_r;
        rdata_nxt   = 32'h0000_0000;
        // Direction is assumed changed only with the channel off
        if (wr_pend_r) begin                                    // [R4]
            case (wr_addr_r)
                `TCM_ADDR_MODE: mode_nxt = hwdata[15:0];        // [R9]
                `TCM_ADDR_CTRL: ctrl_nxt = hwdata[6:0];
                default:        ;                               // Unmapped write dropped
            endcase
        end
        if (addr_phase && !hwrite) begin
            case (haddr[AW-1:0])
                `TCM_ADDR_MODE: rdata_nxt = {16'h0000, mode_nxt};
                `TCM_ADDR_CTRL: rdata_nxt = {25'h0000000, ctrl_nxt};
                `TCM_ADDR_STAT: rdata_nxt = {14'h0000, filt4, filt3, cnt4_r, cnt3_r};
                default:        rdata_nxt = 32'h0000_0000;      // Unmapped reads zero
            endcase
        end
    end

    // Capture next values: rising edge, divider, event count
    always_comb begin
        cap3_nxt.is_input = dir3 != TCM_DIR_OUT;
        cap4_nxt.is_input = dir4 != TCM_DIR_OUT;
        cap3_nxt.capture  = 1'b0;
        cap4_nxt.capture  = 1'b0;
        div3_nxt          = div3_r;
        div4_nxt          = div4_r;
        cnt3_nxt          = cnt3_r;
        cnt4_nxt          = cnt4_r;
        if (!ctrl_r[`TCM_F_CH3_EN]) begin
            div3_nxt = 3'h0;                                    // [R7]
        end else if (cap3_nxt.is_input && src3 && !src3_q_r) begin
            // Terminal count is divisor minus one
            if (div3_r == 3'(4'h1 << mode_r[`TCM_F_CH3_DIV]) - 3'h1) begin // [R7]
                div3_nxt         = 3'h0;
                cap3_nxt.capture = 1'b1;
                cnt3_nxt         = 8'(cnt3_r + 8'h01);
            end else begin
                div3_nxt = 3'(div3_r + 3'h1);
            end
        end
        if (!ctrl_r[`TCM_F_CH4_EN]) begin
            div4_nxt = 3'h0;                                    // [R7]
        end else if (cap4_nxt.is_input && src4 && !src4_q_r) begin
            if (div4_r == 3'(4'h1 << mode_r[`TCM_F_CH4_DIV]) - 3'h1) begin // [R5]
                div4_nxt         = 3'h0;
                cap4_nxt.capture = 1'b1;
                cnt4_nxt         = 8'(cnt4_r + 8'h01);
            end else begin
                div4_nxt = 3'(div4_r + 3'h1);
            end
        end
    end

    // Register stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
            rdata_r   <= 32'h0000_0000;
            ready_r   <= 1'b0;
            mode_r    <= `TCM_MODE_RST;                         // [R9]
            ctrl_r    <= `TCM_CTRL_RST;
            div3_r    <= 3'h0;
            div4_r    <= 3'h0;
            src3_q_r  <= 1'b0;
            src4_q_r  <= 1'b0;
            cnt3_r    <= 8'h00;
            cnt4_r    <= 8'h00;
            cap3_r    <= '0;
            cap4_r    <= '0;
            oc3_r     <= '0;
            oc4_r     <= '0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r   <= rdata_nxt;
            ready_r   <= 1'b1;                                  // Zero wait states
            mode_r    <= mode_nxt;
            ctrl_r    <= ctrl_nxt;
            div3_r    <= div3_nxt;
            div4_r    <= div4_nxt;
            src3_q_r  <= src3;
            src4_q_r  <= src4;
            cnt3_r    <= cnt3_nxt;
            cnt4_r    <= cnt4_nxt;
            cap3_r    <= cap3_nxt;
            cap4_r    <= cap4_nxt;
            // Output view of the same bits, one cycle behind
            oc3_r     <= {mode_r[`TCM_F_CH3_SWITCH], mode_r[`TCM_F_CH3_CTRL],
                          mode_r[`TCM_F_CH3_BUF], mode_r[`TCM_F_CH3_IMM]}; // [R6]
            oc4_r     <= {mode_r[`TCM_F_CH4_SWITCH], mode_r[`TCM_F_CH4_CTRL],
                          mode_r[`TCM_F_CH4_BUF], mode_r[`TCM_F_CH4_IMM]}; // [R6]
        end
    end

    chk_ch4_route: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        (dir4 == TCM_DIR_CROSS) |-> src4 == filt3)
        else $error("channel 4 cross route wrong");

    chk_ch3_route: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
        (dir3 == TCM_DIR_OWN) |-> src3 == filt3)
        else $error("channel 3 own route wrong");

    chk_trig_gate: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
        (dir4 == TCM_DIR_TRIG && ctrl_r[`TCM_F_TRIG_SEL] > `TCM_TRIG_INT_MAX) |-> !src4)
        else $error("trigger routed from external source");

    chk_div_by_one: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
        (ctrl_r[`TCM_F_CH4_EN] && dir4 != TCM_DIR_OUT && mode_r[`TCM_F_CH4_DIV] == 2'h0
         && src4 && !src4_q_r) |=> cap4_r.capture)
        else $error("undivided edge gave no capture");

    chk_out_view: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
        ##1 oc4_r.control == $past(mode_r[`TCM_F_CH4_CTRL]))
        else $error("output control field not forwarded");

    chk_div_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
        !ctrl_r[`TCM_F_CH3_EN] |=> div3_r == 3'h0 && !cap3_r.capture)
        else $error("divider not cleared while disabled");

    chk_cap_spacing: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
        (cap3_r.capture && mode_r[`TCM_F_CH3_DIV] == 2'h1) |=> !cap3_r.capture)
        else $error("divide by two captured twice running");

    chk_mode_write: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
        (wr_pend_r && wr_addr_r == `TCM_ADDR_MODE) |=> mode_r == $past(hwdata[15:0]))
        else $error("mode register write lost");

endmodule : tcm_top

/* tb/tb_timer_channel34_mode_config.sv */
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tb_timer_channel34_mode_config;
    import tcm_pkg::*;

    logic                 hclk;        // 125 MHz bus clock
    logic                 hresetn;     // Active-low reset
    logic                 hsel;        // Master request signals
    logic          [31:0] haddr;
    logic           [1:0] htrans;
    logic                 hwrite;
    logic           [2:0] hsize;
    logic          [31:0] hwdata;
    wire logic            hready;      // Single slave: its own ready
    logic          [31:0] hrdata;
    logic                 hreadyout;
    logic                 hresp;
    logic           [2:0] lines;       // Pins and trigger
    tcm_out_cfg_t         cfg3;
    tcm_out_cfg_t         cfg4;
    tcm_cap_t             cap3;
    tcm_cap_t             cap4;
    logic                 rd_phase;    // Read data phase open
    logic          [31:0] exp_q[$];    // Expected read data
    logic           [7:0] cnt3;        // Expected capture counts
    logic           [7:0] cnt4;
    logic           [7:0] seen3 = 8'h00; // Capture pulses seen on the outputs
    logic           [7:0] seen4 = 8'h00;
    logic          [15:0] v;
    int                   err_count;
    int                   compares;

    assign hready = hreadyout;

    tcm_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ch3_pin(lines[0]), .ch4_pin(lines[1]), .slave_trigger_input(lines[2]),
        .ch3_out_cfg(cfg3), .ch4_out_cfg(cfg4), .ch3_cap(cap3), .ch4_cap(cap4));

    tcm_pin_model pins (.hclk(hclk), .src_lines(lines));

    // Clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // One compare task per kind of result
    task automatic check_rd(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : check_rd

    task automatic check_cfg(input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : check_cfg

    // Single AHB-Lite transfer; waits on ready in both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h000000, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel     <= 1'b0;
        htrans   <= 2'h0;
        hwdata   <= d;
        rd_phase <= ~wr;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_phase <= 1'b0;
    endtask : bus

    // Note the expectation, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h00000000);
    endtask : rd

    // Status: counts low, filtered levels low while pins idle
    task automatic rd_stat();
        rd(`TCM_ADDR_STAT, {16'h0000, cnt4, cnt3});
        check_rd({16'h0000, cnt4, cnt3}, {16'h0000, seen4, seen3});
    endtask : rd_stat

    // Reconfigure only with both channels disabled, then enable
    task automatic setup(input logic [15:0] m, input logic [31:0] c);
        bus(1'b1, `TCM_ADDR_CTRL, 32'h00000000);
        bus(1'b1, `TCM_ADDR_MODE, {16'h0000, m});
        bus(1'b1, `TCM_ADDR_CTRL, c);
    endtask : setup

    // Read data taken at the edge that ends the data phase
    always @(posedge hclk) begin
        if (rd_phase && hready === 1'b1) begin
            check_rd(exp_q.pop_front(), hrdata);
        end
        // Capture pulses counted as they appear, one cycle each
        if (cap3.capture === 1'b1) begin
            seen3 <= 8'(seen3 + 8'h01);
        end
        if (cap4.capture === 1'b1) begin
            seen4 <= 8'(seen4 + 8'h01);
        end
    end

    task automatic give_verdict();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // Watchdog, well beyond the expected run of under two thousand cycles
    initial begin
        #400000;
        err_count++;
        give_verdict();
    end

    // Main sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; rd_phase = 1'b0;
        cnt3 = 8'h00; cnt4 = 8'h00; err_count = 0; compares = 0;
        void'($urandom(32'h94A5CDCC));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);

        bus(1'b1, `TCM_ADDR_STAT, 32'hFFFFFFFF);
        rd_stat();
        rd(`TCM_ADDR_MODE, 32'h00000000);
        rd(8'h20, 32'h00000000);
        $display("test reset done");

        // Random layouts: read back and output view, upper bits dropped
        repeat (6) begin
            v = 16'($urandom());
            bus(1'b1, `TCM_ADDR_MODE, {16'($urandom()), v});
            rd(`TCM_ADDR_MODE, {16'h0000, v});
            repeat (3) @(posedge hclk);
            check_cfg({v[15:10], v[7:2]}, {cfg4, cfg3});
            check_rd({29'h0, 1'b0, |v[9:8], |v[1:0]}, {29'h0, hresp, cap4.is_input, cap3.is_input});
        end
        $display("test layout done");

        // Routing: wrong pin gives nothing, right pin one capture
        for (int i = 0; i < 4; i++) begin
            setup(i == 0 ? 16'h0001 : i == 1 ? 16'h0002 : i == 2 ? 16'h0100 : 16'h0200,
                32'h00000003);
            pins.pulse((i == 1 || i == 2) ? 0 : 1, 4);
            rd_stat();
            pins.pulse((i == 1 || i == 2) ? 1 : 0, 4);
            if (i < 2) cnt3++;
            else cnt4++;
            rd_stat();
        end
        $display("test routing done");

        // Trigger only with an internal source selected
        setup(16'h0003, 32'h00000041);
        pins.pulse(2, 2);
        rd_stat();
        bus(1'b1, `TCM_ADDR_CTRL, 32'h00000031);
        pins.pulse(2, 2);
        cnt3++;
        rd_stat();
        $display("test trigger done");

        // Divider per code; 9 edges leave a remainder for codes 1 to 3 that the disable clears
        for (int ch = 0; ch < 2; ch++) begin
            for (int d = 0; d < 4; d++) begin
                setup(ch == 0 ? 16'(d * 4 + 3) : 16'(d * 1024 + 768), 32'(1 << ch));
                repeat (9) pins.pulse(2, 2);
                if (ch == 0) cnt3 += 8'(9 >> d);
                else cnt4 += 8'(9 >> d);
                rd_stat();
            end
        end
        $display("test divider done");

        // Ch4 filter code 3: short glitch dropped, long level passes
        setup(16'h3100, 32'h00000002);
        pins.pulse(1, 3);
        rd_stat();
        pins.pulse(1, 20 + $urandom_range(0, 8));
        cnt4++;
        rd_stat();
        $display("test filter done");

        give_verdict();
    end
endmodule : tb_timer_channel34_mode_config

/* tb/tcm_pin_model.sv */
`timescale 1ns/1ps

// Far side: two channel pins and the internal trigger, idle low
module tcm_pin_model (
    // Clock
    input  wire logic       hclk,
    // Source lines: 0 ch3 pin, 1 ch4 pin, 2 trigger
    output logic      [2:0] src_lines
);
    initial src_lines = 3'h0;

    // High for hi cycles, then a long gap so each capture settles
    // before the next edge; trigger stays synchronous to hclk
    task automatic pulse(input int src, input int hi);
        @(posedge hclk);
        src_lines[src] <= 1'b1;
        repeat (hi) @(posedge hclk);
        src_lines[src] <= 1'b0;
        repeat (14) @(posedge hclk);
    endtask : pulse
endmodule : tcm_pin_model
